// [core/pmpw_map.vh]
// register map, field positions and reset values of the power monitor warning block
`ifndef PMPW_MAP_VH
`define PMPW_MAP_VH

// byte offsets
`define PMPW_CTRL        8'h00
`define PMPW_STATUS      8'h04
`define PMPW_MASK        8'h08
`define PMPW_CLEAR       8'h0c
`define PMPW_THR_BASE    8'h10
`define PMPW_PEAK_BASE   8'h30
`define PMPW_RD_VIN      8'h40
`define PMPW_RD_VOUT     8'h44
`define PMPW_RD_IOUT     8'h48
`define PMPW_RD_PIN      8'h4c
`define PMPW_RD_PIN_EXT  8'h50
`define PMPW_RD_EIN_EXT  8'h54
`define PMPW_RD_EIN      8'h58

// threshold indices, offset = base + 4*index
`define PMPW_T_VIN_OV    3'd0
`define PMPW_T_VIN_UV    3'd1
`define PMPW_T_VOUT_OV   3'd2
`define PMPW_T_VOUT_UV   3'd3
`define PMPW_T_IOUT_OC   3'd4
`define PMPW_T_IOUT_W2   3'd5
`define PMPW_T_PIN_OP    3'd6

// peak indices, offset = base + 4*index
`define PMPW_P_IOUT      2'd0
`define PMPW_P_VIN       2'd1
`define PMPW_P_VOUT      2'd2
`define PMPW_P_PIN       2'd3

// control bits
`define PMPW_C_VOUT_EN   0
`define PMPW_C_RANGE_HI  1
`define PMPW_C_W2_OVER   2
`define PMPW_CTRL_RST    3'h5

// status bits
`define PMPW_S_VIN_OV    0
`define PMPW_S_VIN_UV    1
`define PMPW_S_VOUT_OV   2
`define PMPW_S_VOUT_UV   3
`define PMPW_S_IOUT_OC   4
`define PMPW_S_IOUT_W2   5
`define PMPW_S_PIN_OP    6

// direct format scale ends
`define PMPW_MIN_SCALE   16'h8000
`define PMPW_MAX_SCALE   16'h7fff

`endif

// [core/pmpw_core.v]
// power monitor peak records, warning comparators, sticky status and register port
`include "pmpw_map.vh"
`default_nettype none

module pmpw_core #(
  parameter NWARN = 7,
  parameter DW    = 16,
  parameter XW    = 24
) (
  // clock and reset
  input  wire          i_mclk,
  input  wire          i_reset_n,
  // register port
  input  wire [7:0]    i_addr,
  input  wire [31:0]   i_wdata,
  input  wire          i_wr,
  input  wire          i_rd,
  output reg  [31:0]   o_rdata,
  // averaged samples from the monitor front end
  input  wire          i_avg_valid,
  input  wire [DW-1:0] i_vin,
  input  wire [DW-1:0] i_vout,
  input  wire [DW-1:0] i_iout,
  input  wire [XW-1:0] i_pin_ext,
  input  wire [XW-1:0] i_ein_ext,
  // front end configuration
  output reg           o_vout_en,
  output reg           o_range_high,
  // interrupt
  output reg           o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // register map notes for the next engineer
  //
  // 0x00 control word
  //   bit 0  vout sampling enable, mirrored on o_vout_en
  //   bit 1  high input voltage range, mirrored on o_range_high
  //   bit 2  second current limit sense: 1 over, 0 under
  //   resets to over sense, range bit low, vout sampling on, while o_range_high itself resets high
  //
  // 0x04 sticky warning status, write one to clear
  //   bit 0  input over-voltage
  //   bit 1  input under-voltage
  //   bit 2  output over-voltage
  //   bit 3  output under-voltage
  //   bit 4  overcurrent
  //   bit 5  second current limit
  //   bit 6  overpower
  //
  // 0x08 interrupt mask, same layout as status, all off at reset
  //
  // 0x0c any write clears every status bit at once
  //
  // 0x10 .. 0x28 warning limits, one 16-bit signed word each
  //   0x10 input over-voltage
  //   0x14 input under-voltage
  //   0x18 output over-voltage
  //   0x1c output under-voltage
  //   0x20 overcurrent
  //   0x24 second current limit
  //   0x28 overpower
  //
  // 0x30 .. 0x3c peak records, readable, a zero write clears one
  //   0x30 current
  //   0x34 input voltage
  //   0x38 output voltage
  //   0x3c input power, 16-bit view
  //
  // 0x40 .. 0x58 latest averaged readings
  //   0x40 input voltage
  //   0x44 output voltage
  //   0x48 current
  //   0x4c input power, 16-bit view
  //   0x50 input power, 24-bit view
  //   0x54 energy accumulator, 24-bit view
  //   0x58 energy accumulator, 16-bit view
  //
  // behaviour notes
  //   every register is one 32-bit word, data in the low bits
  //   unused upper bits read as zero, unmapped reads return zero
  //   writes to read-only or unmapped offsets are dropped
  //   a nonzero write to a peak record is dropped, not stored
  //   read data stands for exactly one cycle, then returns to zero
  //   the bus never stalls, so back to back strobes are fine
  //
  // sampling notes
  //   all limits are checked on the same averaged strobe
  //   raw conversions never reach this block, only averages
  //   a cleared peak sits at minimum scale so any sample above minimum scale wins
  //   a peak clear beats a sample landing in the same cycle
  //   vout peak, reading and warnings freeze while sampling is off
  //
  // clearing notes
  //   the last sample's verdict is kept in cond
  //   a clear while cond still holds leaves the bit set
  //   a sample hit and a clear in one cycle: the set wins
  //
  // interrupt notes
  //   o_irq is registered from the next status and next mask
  //   so a mask write shows on the pin at the same edge
  //   as the mask register itself, with no extra lag
  //
  // scaling notes
  //   power and energy arithmetic live in the front end
  //   the range bit only steers that front end scaling
  //   the 16-bit views are the top bits of the 24-bit ones
  //   so the wide views are 256 times the narrow ones
  //
  // limitations
  //   thresholds are compared as raw direct-format codes
  //   no unit conversion happens inside this block
  //   changing control while sampling may give one odd result
  //   software should stop sampling before reconfiguring
  //

  ////////////////////////////////////////////////////////////////////////
  // storage

  reg  [2:0]       ctrl;
  reg  [NWARN-1:0] status;
  reg  [NWARN-1:0] mask;
  reg  [NWARN-1:0] cond;
  reg  [DW-1:0]    thr [0:NWARN-1];
  reg  [DW-1:0]    peak [0:3];
  reg  [DW-1:0]    last_vin;
  reg  [DW-1:0]    last_vout;
  reg  [DW-1:0]    last_iout;
  reg  [XW-1:0]    last_pin_ext;
  reg  [XW-1:0]    last_ein_ext;

  wire [DW-1:0]    pin16;
  wire [DW-1:0]    ein16;
  wire             wr_thr;
  wire             wr_peak;
  wire [2:0]       thr_idx;
  wire [1:0]       peak_idx;
  wire             clr_all;
  wire [NWARN-1:0] clr_w1c;
  wire [NWARN-1:0] next_mask;

  // 16-bit views are the top of the 24-bit values
  assign pin16 = i_pin_ext[XW-1:XW-DW];
  assign ein16 = last_ein_ext[XW-1:XW-DW];

  // address decode
  assign wr_thr   = i_wr && (i_addr >= `PMPW_THR_BASE) && (i_addr < `PMPW_THR_BASE + 8'h1c)
                    && (i_addr[1:0] == 2'b00);
  assign wr_peak  = i_wr && ({i_addr[7:4], 4'h0} == `PMPW_PEAK_BASE) && (i_addr[1:0] == 2'b00);
  assign thr_idx  = i_addr[4:2] - 3'h4;
  assign peak_idx = i_addr[3:2];
  assign clr_all  = i_wr && (i_addr == `PMPW_CLEAR);
  assign clr_w1c  = (i_wr && (i_addr == `PMPW_STATUS)) ? i_wdata[NWARN-1:0] : {NWARN{1'b0}};
  // mask seen by the interrupt in the same cycle it is written
  assign next_mask = (i_wr && (i_addr == `PMPW_MASK)) ? i_wdata[NWARN-1:0] : mask;

  ////////////////////////////////////////////////////////////////////////
  // warning comparators, all evaluated on the same averaged sample

  reg [NWARN-1:0] hit;
  reg             vout_on;

  always @* begin
    vout_on = ctrl[`PMPW_C_VOUT_EN];
    hit = {NWARN{1'b0}};
    // strict compares: equality never warns
    hit[`PMPW_S_VIN_OV]  = $signed(i_vin) > $signed(thr[`PMPW_T_VIN_OV]);
    hit[`PMPW_S_VIN_UV]  = $signed(i_vin) < $signed(thr[`PMPW_T_VIN_UV]);
    hit[`PMPW_S_VOUT_OV] = vout_on && ($signed(i_vout) > $signed(thr[`PMPW_T_VOUT_OV]));
    hit[`PMPW_S_VOUT_UV] = vout_on && ($signed(i_vout) < $signed(thr[`PMPW_T_VOUT_UV]));
    hit[`PMPW_S_IOUT_OC] = $signed(i_iout) > $signed(thr[`PMPW_T_IOUT_OC]);
    // second current limit: polarity bit picks over or under
    if (ctrl[`PMPW_C_W2_OVER]) begin
      hit[`PMPW_S_IOUT_W2] = $signed(i_iout) > $signed(thr[`PMPW_T_IOUT_W2]);
    end else begin
      hit[`PMPW_S_IOUT_W2] = $signed(i_iout) < $signed(thr[`PMPW_T_IOUT_W2]);
    end
    hit[`PMPW_S_PIN_OP]  = $signed(pin16) > $signed(thr[`PMPW_T_PIN_OP]);
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status next value: set beats any clear

  reg [NWARN-1:0] next_status;
  reg [NWARN-1:0] next_cond;

  always @* begin
    next_cond = cond;
    if (i_avg_valid) begin
      next_cond = hit;
    end else if (!ctrl[`PMPW_C_VOUT_EN]) begin
      // a disabled channel holds no live vout condition
      next_cond[`PMPW_S_VOUT_OV] = 1'b0;
      next_cond[`PMPW_S_VOUT_UV] = 1'b0;
    end
    next_status = status & ~clr_w1c;
    if (clr_all) begin
      next_status = {NWARN{1'b0}};
    end
    if (i_avg_valid) begin
      next_status = next_status | hit;
    end
    // a clear while the condition still holds sets the bit again
    if (clr_all || (|clr_w1c)) begin
      next_status = next_status | cond;
    end
  end

  always @(posedge i_mclk) begin
    if (!i_reset_n) begin
      status <= {NWARN{1'b0}};
      cond   <= {NWARN{1'b0}};
      o_irq  <= 1'b0;
    end else begin
      status <= next_status;
      cond   <= next_cond;
      o_irq  <= |(next_status & next_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control, mask and thresholds

  integer k;

  always @(posedge i_mclk) begin
    if (!i_reset_n) begin
      ctrl         <= `PMPW_CTRL_RST;
      mask         <= {NWARN{1'b0}};
      o_vout_en    <= 1'b1;
      o_range_high <= 1'b1;
      // limits start at the scale ends so no warning fires
      thr[`PMPW_T_VIN_OV]  <= `PMPW_MAX_SCALE;
      thr[`PMPW_T_VIN_UV]  <= `PMPW_MIN_SCALE;
      thr[`PMPW_T_VOUT_OV] <= `PMPW_MAX_SCALE;
      thr[`PMPW_T_VOUT_UV] <= `PMPW_MIN_SCALE;
      thr[`PMPW_T_IOUT_OC] <= `PMPW_MAX_SCALE;
      thr[`PMPW_T_IOUT_W2] <= `PMPW_MAX_SCALE;
      thr[`PMPW_T_PIN_OP]  <= `PMPW_MAX_SCALE;
    end else begin
      if (i_wr && (i_addr == `PMPW_CTRL)) begin
        ctrl         <= i_wdata[2:0];
        o_vout_en    <= i_wdata[`PMPW_C_VOUT_EN];
        // range choice sets the power scaling in the front end
        o_range_high <= i_wdata[`PMPW_C_RANGE_HI];
      end
      if (i_wr && (i_addr == `PMPW_MASK)) begin
        mask <= i_wdata[NWARN-1:0];
      end
      if (wr_thr) begin
        thr[thr_idx] <= i_wdata[DW-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // peak records and latest readings

  reg [DW-1:0] samp [0:3];

  always @* begin
    samp[`PMPW_P_IOUT] = i_iout;
    samp[`PMPW_P_VIN]  = i_vin;
    samp[`PMPW_P_VOUT] = i_vout;
    samp[`PMPW_P_PIN]  = pin16;
  end

  always @(posedge i_mclk) begin
    if (!i_reset_n) begin
      for (k = 0; k < 4; k = k + 1) begin
        peak[k] <= `PMPW_MIN_SCALE;
      end
      last_vin     <= {DW{1'b0}};
      last_vout    <= {DW{1'b0}};
      last_iout    <= {DW{1'b0}};
      last_pin_ext <= {XW{1'b0}};
      last_ein_ext <= {XW{1'b0}};
    end else begin
      for (k = 0; k < 4; k = k + 1) begin
        // only averaged results reach the peak records
        if (i_avg_valid && !(k == `PMPW_P_VOUT && !ctrl[`PMPW_C_VOUT_EN])
            && ($signed(samp[k]) > $signed(peak[k]))) begin
          peak[k] <= samp[k];
        end
        // a zero write clears just the addressed record; clear wins the cycle
        if (wr_peak && (peak_idx == k[1:0]) && (i_wdata[DW-1:0] == {DW{1'b0}})) begin
          peak[k] <= `PMPW_MIN_SCALE;
        end
      end
      if (i_avg_valid) begin
        last_vin     <= i_vin;
        last_iout    <= i_iout;
        last_pin_ext <= i_pin_ext;
        last_ein_ext <= i_ein_ext;
        if (ctrl[`PMPW_C_VOUT_EN]) begin
          last_vout <= i_vout;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe, zero otherwise

  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        `PMPW_CTRL:       next_rdata = {29'h0, ctrl};
        `PMPW_STATUS:     next_rdata = {{(32-NWARN){1'b0}}, status};
        `PMPW_MASK:       next_rdata = {{(32-NWARN){1'b0}}, mask};
        `PMPW_RD_VIN:     next_rdata = {16'h0000, last_vin};
        `PMPW_RD_VOUT:    next_rdata = {16'h0000, last_vout};
        `PMPW_RD_IOUT:    next_rdata = {16'h0000, last_iout};
        `PMPW_RD_PIN:     next_rdata = {16'h0000, last_pin_ext[XW-1:XW-DW]};
        `PMPW_RD_PIN_EXT: next_rdata = {8'h00, last_pin_ext};
        `PMPW_RD_EIN_EXT: next_rdata = {8'h00, last_ein_ext};
        `PMPW_RD_EIN:     next_rdata = {16'h0000, ein16};
        default: begin
          if (wr_thr_rd(i_addr)) begin
            next_rdata = {16'h0000, thr[i_addr[4:2] - 3'h4]};
          end else if (({i_addr[7:4], 4'h0} == `PMPW_PEAK_BASE) && (i_addr[1:0] == 2'b00)) begin
            next_rdata = {16'h0000, peak[i_addr[3:2]]};
          end else begin
            next_rdata = 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // threshold window decode shared with the read path
  function wr_thr_rd;
    input [7:0] a;
    begin
      wr_thr_rd = (a >= `PMPW_THR_BASE) && (a < `PMPW_THR_BASE + 8'h1c) && (a[1:0] == 2'b00);
    end
  endfunction

  always @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule // pmpw_core

`default_nettype wire

// [tb/pmpw_chk_properties.sv]
// port assertions of the power monitor warning block
`default_nettype none
module pmpw_chk (
  // clock, reset and strobes
  input wire logic        i_mclk,
  input wire logic        i_reset_n,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_avg_valid,
  // watched outputs
  input wire logic [31:0] o_rdata,
  input wire logic        o_irq,
  input wire logic        o_vout_en,
  input wire logic        o_range_high
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // read answer lands one cycle after its strobe
  sequence s_read;
    i_rd ##1 1'b1;
  endsequence
  ////////////////////////////////////////
  a_rdata_width: assert property (s_read |-> o_rdata[31:24] == 8'h00)
    else $error("read data wider than 24 bits");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside answer cycle");
  // irq only follows a sample or a register write
  a_irq_cause: assert property ($rose(o_irq) |-> $past(i_avg_valid || i_wr))
    else $error("irq rose without cause");
  a_irq_latched: assert property (o_irq && !i_wr |=> o_irq)
    else $error("warning dropped without clear");
  a_range_held: assert property (!$past(i_wr) |-> $stable(o_range_high))
    else $error("range changed without write");
  a_vout_held: assert property (!$past(i_wr) |-> $stable(o_vout_en))
    else $error("vout enable changed without write");
  a_reset_quiet: assert property (disable iff (1'b0) !i_reset_n |=> !o_irq && o_rdata == 32'h0)
    else $error("outputs busy after reset");
  a_reset_cfg: assert property (disable iff (1'b0) !i_reset_n |=> o_vout_en && o_range_high)
    else $error("config not at reset value");
endmodule // pmpw_chk
bind pmpw_core pmpw_chk u_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_wr(i_wr), .i_rd(i_rd),
  .i_avg_valid(i_avg_valid), .o_rdata(o_rdata), .o_irq(o_irq), .o_vout_en(o_vout_en),
  .o_range_high(o_range_high));
`default_nettype wire

// [tb/pmpw_host.sv]
// register bus host model of the power monitor
`default_nettype none
module pmpw_host (
  // clock and answer
  input  wire logic        i_mclk,
  input  wire logic [31:0] i_rdata,
  // request lines
  output var  logic [7:0]  o_addr,
  output var  logic [31:0] o_wdata,
  output var  logic        o_wr,
  output var  logic        o_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    o_addr = 8'hff;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // one strobe cycle; lines scrambled after so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask
endmodule // pmpw_host
`default_nettype wire

// [tb/power_monitor_peak_and_warning_test.sv]
// self-checking bench of the power monitor warning block
`include "pmpw_map.vh"
`default_nettype none
module power_monitor_peak_and_warning_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        avg = 1'b0;
  logic [15:0] vin = 16'h0, vout = 16'h0, iout = 16'h0;
  logic [23:0] pin = 24'h0, ein = 24'h0;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic        wr, rd, vout_en, range_hi, irq;
  int          n_fail = 0, checks = 0;
  pmpw_core i_dut (.i_mclk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_avg_valid(avg), .i_vin(vin), .i_vout(vout), .i_iout(iout), .i_pin_ext(pin),
    .i_ein_ext(ein), .o_vout_en(vout_en), .o_range_high(range_hi), .o_irq(irq));
  pmpw_host i_host (.i_mclk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  // 200 MHz clock
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // registered outputs settle after the edge that launched them
  task automatic ochk(input logic seen_bit, input logic exp_bit);
    chk(32'(seen_bit), 32'(exp_bit));
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    i_host.rd(a, d);
    chk(d, exp);
  endtask
  // one averaged sample; energy kept distinct from power
  task automatic smp(input logic [15:0] v, input logic [15:0] o, input logic [15:0] c, input logic [23:0] p);
    @(posedge clk);
    avg <= 1'b1;
    vin <= v;
    vout <= o;
    iout <= c;
    pin <= p;
    ein <= p + 24'h000100;
    @(posedge clk);
    avg <= 1'b0;
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    rchk(`PMPW_CTRL, 32'h5);
    for (int i = 0; i < 7; i++)
      rchk(`PMPW_THR_BASE + 8'(4 * i), (i == 1 || i == 3) ? 32'h8000 : 32'h7fff);
    for (int i = 0; i < 4; i++)
      rchk(`PMPW_PEAK_BASE + 8'(4 * i), 32'h8000);
    rchk(8'h5c, 32'h0);
    smp(16'h7fff, 16'h8000, 16'h7fff, 24'h7fffff);
    rchk(`PMPW_STATUS, 32'h0);
  endtask
  // equality must stay quiet; vin high with vout low catches swapped channels
  task automatic t_warn;
    i_host.wr(`PMPW_MASK, 32'h7f);
    for (int i = 0; i < 7; i++)
      i_host.wr(`PMPW_THR_BASE + 8'(4 * i), (i == 1 || i == 3) ? 32'h32 : 32'h64);
    smp(16'h64, 16'h32, 16'h64, 24'h6400);
    rchk(`PMPW_STATUS, 32'h0);
    smp(16'h65, 16'h31, 16'h65, 24'h6500);
    rchk(`PMPW_STATUS, 32'h79);
    chk(32'(irq), 32'h1);
    i_host.wr(`PMPW_STATUS, 32'h7f);
    rchk(`PMPW_STATUS, 32'h79);
    smp(16'h40, 16'h40, 16'h40, 24'h4000);
    i_host.wr(`PMPW_STATUS, 32'h7f);
    rchk(`PMPW_STATUS, 32'h0);
    smp(16'h31, 16'h65, 16'h40, 24'h0);
    rchk(`PMPW_STATUS, 32'h06);
    i_host.wr(`PMPW_MASK, 32'h1);
    @(negedge clk);
    ochk(irq, 1'b0);
    i_host.wr(`PMPW_MASK, 32'h7f);
    @(negedge clk);
    ochk(irq, 1'b1);
    smp(16'h40, 16'h40, 16'h40, 24'h4000);
    i_host.wr(`PMPW_CLEAR, 32'h1);
    @(negedge clk);
    ochk(irq, 1'b0);
  endtask
  task automatic t_w2;
    i_host.wr(`PMPW_CTRL, 32'h0);
    @(negedge clk);
    ochk(range_hi, 1'b0);
    ochk(vout_en, 1'b0);
    smp(16'h40, 16'h100, 16'h63, 24'h0);
    rchk(`PMPW_STATUS, 32'h20);
    i_host.wr(`PMPW_CTRL, 32'h5);
    @(negedge clk);
    ochk(vout_en, 1'b1);
    ochk(range_hi, 1'b0);
    smp(16'h40, 16'h40, 16'h40, 24'h4000);
    i_host.wr(`PMPW_CLEAR, 32'h1);
  endtask
  // peaks cleared, two samples, then raw input change without strobe
  task automatic t_peak;
    for (int i = 0; i < 4; i++)
      i_host.wr(`PMPW_PEAK_BASE + 8'(4 * i), 32'h0);
    smp(16'h50, 16'h40, 16'h30, 24'h2000);
    smp(16'h20, 16'h45, 16'h35, 24'h1000);
    @(posedge clk);
    vin <= 16'h7000;
    rchk(`PMPW_PEAK_BASE, 32'h35);
    rchk(`PMPW_PEAK_BASE + 8'h4, 32'h50);
    rchk(`PMPW_PEAK_BASE + 8'h8, 32'h45);
    rchk(`PMPW_PEAK_BASE + 8'hc, 32'h20);
    rchk(`PMPW_RD_PIN_EXT, 32'h1000);
    rchk(`PMPW_RD_EIN_EXT, 32'h1100);
    rchk(`PMPW_RD_EIN, 32'h11);
    i_host.wr(`PMPW_PEAK_BASE, 32'h0);
    i_host.wr(`PMPW_PEAK_BASE + 8'h4, 32'h1);
    rchk(`PMPW_PEAK_BASE, 32'h8000);
    rchk(`PMPW_PEAK_BASE + 8'h4, 32'h50);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_warn;
    t_w2;
    t_peak;
    print_verdict;
  end
  // whole run is under 150 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    print_verdict;
  end
endmodule // power_monitor_peak_and_warning_test
`default_nettype wire
